//--- hdl/dmm_pkg.sv
// Shared widths, timing figures and control carrier for the dual multiply-accumulate mixer
package dmm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Data widths
  localparam int OP_W    = 12;               // Operand width
  localparam int PROD_W  = 24;               // Full product width
  localparam int ACC_W   = 24;               // Accumulator width
  localparam int CHAIN_W = 16;               // Chain input width
  localparam int RES_W   = 16;               // Result word width
  localparam int TAP_W   = 4;                // Tap select width
  localparam int N_OPS   = 4;                // Operands a, b, c, d

  ////////////////////////////////////////////////////////////////////////////
  // Structure and field positions
  localparam int STK_DEPTH = 16;             // Stages per delay stack
  localparam int CHAIN_DLY = 3;              // Chain alignment registers
  localparam int CTL_DEPTH = 5;              // Control pipeline stages
  localparam int UPPER_LSB = 8;              // Lowest bit of the upper word
  localparam int RND_BIT   = 7;              // Half-LSB of the upper word

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;         // Result after reset
  localparam logic [ACC_W-1:0] RND_ONE = 24'h000080;       // One at the round bit
  localparam logic [CHAIN_W-1:0] CHAIN_ZERO = 16'h0000;    // Gated chain value

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20;         // 50 MHz clock

  ////////////////////////////////////////////////////////////////////////////
  // Control word that travels alongside the data
  typedef struct packed {
    logic neg_ab;                            // Negate product a*b
    logic neg_cd;                            // Negate product c*d
    logic cont;                              // Keep accumulating
    logic rnd;                               // Round request
    logic bypass;                            // Chain skips alignment
    logic upper;                             // Upper word to result
  } dmm_ctl_t;

  localparam dmm_ctl_t CTL_RST = '0;         // Control pipeline after reset

endpackage : dmm_pkg

//--- hdl/dmm_mixer.sv
// Dual multiply-accumulate mixer datapath with delay stacks and three-state result
//
// How it works
// RULE1: all state updates on rising clock only; reset clears the control pipeline and result stage asynchronously here
// RULE2: four 12-bit operands registered every edge
// RULE3: input register enters stack top next clock
// RULE4: 16-bit chain input registered every edge
// RULE5: push gate low pushes and shifts stack
// RULE6: push gate high holds stack, drops input
// RULE7: tap code selects stage, 0 to 15
// RULE8: driver must initialise taps and stacks
// RULE9: invert controls negate products, subtracting them
// RULE10: negate acts on same-cycle operands, taps zero
// RULE11: chain gate low adds chain, high ignores
// RULE12: chain delayed three clocks to align
// RULE13: bypass skips the three chain delays
// RULE14: continue low restarts with current sum
// RULE15: continue high adds sum to total
// RULE16: round only in first accumulation cycle
// RULE17: upper select loads upper word each cycle
// RULE18: select low alternates lower, holds results
// RULE19: result carries upper or lower word
// RULE20: drive gate low drives pins, else released
// RULE21: drive gate acts without clocking
// RULE22: two 12x12 multipliers feed 24-bit accumulator
// RULE23: controls pipelined to match their data
// RULE24: rounding adds one below upper word
// RULE25: all values signed, sign extended
`timescale 1ns/100ps

module dmm_mixer #(
  parameter int OP_W      = dmm_pkg::OP_W,       // Operand width
  parameter int STK_DEPTH = dmm_pkg::STK_DEPTH   // Stack depth
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  // Operands
  input  wire logic [OP_W-1:0]              operand_a_i,
  input  wire logic [OP_W-1:0]              operand_b_i,
  input  wire logic [OP_W-1:0]              operand_c_i,
  input  wire logic [OP_W-1:0]              operand_d_i,
  // Stack control, index 0..3 = a..d
  input  wire logic [dmm_pkg::N_OPS-1:0]    stack_push_gate_n_i,
  input  wire logic [dmm_pkg::N_OPS-1:0][dmm_pkg::TAP_W-1:0] tap_select_i,
  // Chain input
  input  wire logic [dmm_pkg::CHAIN_W-1:0]  chain_in_port_i,
  input  wire logic                         chain_gate_n_i,
  input  wire logic                         chain_align_bypass_i,
  // Arithmetic controls
  input  wire logic                         product_invert_ab_i,
  input  wire logic                         product_invert_cd_i,
  input  wire logic                         sum_continue_i,
  input  wire logic                         round_request_i,
  input  wire logic                         upper_word_select_i,
  // Result pins
  input  wire logic                         pin_drive_gate_n_i,
  output logic      [dmm_pkg::RES_W-1:0]    result_out_o,
  output logic                              result_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int NOPS = dmm_pkg::N_OPS;
  localparam int AW   = dmm_pkg::ACC_W;
  localparam int CW   = dmm_pkg::CHAIN_W;

  logic [NOPS-1:0][OP_W-1:0]     in_r;       // Operand input registers
  logic [NOPS-1:0]               gate_n_r;   // Push gates, with their data
  logic [NOPS-1:0][dmm_pkg::TAP_W-1:0] tap_r; // Registered tap selects
  logic [OP_W-1:0]               stk_r [NOPS][STK_DEPTH]; // Delay stacks
  logic [NOPS-1:0][OP_W-1:0]     tap_out;    // Selected stage per operand
  logic signed [AW-1:0]          op_ext [NOPS]; // Tapped operands, sign extended
  logic signed [AW-1:0]          prod_ab_r;  // Product a*b
  logic signed [AW-1:0]          prod_cd_r;  // Product c*d
  logic signed [AW-1:0]          sum_r;      // Signed sum of products
  logic signed [AW-1:0]          sum_nxt;
  logic [CW-1:0]                 chain_r;    // Chain input register
  logic [CW-1:0]                 chn_d_r [dmm_pkg::CHAIN_DLY]; // Alignment delays
  logic signed [AW-1:0]          chain_ext;  // Selected chain, sign extended
  logic signed [AW-1:0]          acc_r;      // Accumulator
  logic signed [AW-1:0]          acc_nxt;
  logic [AW-1:0]                 hold_r;     // Frozen accumulator for lower reads
  logic                          phase_r;    // High when lower word is due
  dmm_pkg::dmm_ctl_t             ctl_in;     // Controls as presented
  dmm_pkg::dmm_ctl_t             ctl_p [1:dmm_pkg::CTL_DEPTH]; // Control pipeline

  ////////////////////////////////////////////////////////////////////////////
  // Input capture; the data path carries no reset, as in the device
  // Taps are registered too, so a new code acts one cycle later
  always_ff @(posedge clk_i) begin                                         // RULE1
    in_r     <= {operand_d_i, operand_c_i, operand_b_i, operand_a_i};    // RULE2
    gate_n_r <= stack_push_gate_n_i;                                       // RULE23
    tap_r    <= tap_select_i;                                             // RULE7
    // Gated chain reads as zero so it adds nothing
    chain_r  <= chain_gate_n_i ? dmm_pkg::CHAIN_ZERO : chain_in_port_i;   // RULE4 RULE11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay stacks; contents are unknown until the driver fills them
  always_ff @(posedge clk_i) begin                                         // RULE8
    for (int k = 0; k < NOPS; k++) begin
      // Low gate pushes; high gate holds and the input is dropped
      if (!gate_n_r[k]) begin                                              // RULE5 RULE6
        stk_r[k][0] <= in_r[k];                                            // RULE3
        for (int s = 1; s < STK_DEPTH; s++) begin
          stk_r[k][s] <= stk_r[k][s-1];
        end
      end
    end
  end

  // Tap mux: code zero is the newest stage, one cycle behind the input
  // A tap deeper than the pushes so far reads stale or unknown words
  always_comb begin
    for (int k = 0; k < NOPS; k++) begin
      tap_out[k] = stk_r[k][tap_r[k]];                                     // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pipeline, matched so taps at zero keep controls with data
  // Reset clears controls and the result stage only; other data path words stay unknown until filled
  assign ctl_in = '{neg_ab: product_invert_ab_i, neg_cd: product_invert_cd_i,
                    cont: sum_continue_i, rnd: round_request_i,
                    bypass: chain_align_bypass_i, upper: upper_word_select_i};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 1; i <= dmm_pkg::CTL_DEPTH; i++) begin
        ctl_p[i] <= dmm_pkg::CTL_RST;
      end
    end else begin
      ctl_p[1] <= ctl_in;                                                  // RULE23
      for (int i = 2; i <= dmm_pkg::CTL_DEPTH; i++) begin
        ctl_p[i] <= ctl_p[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Widen first: a product of two 12-bit terms needs all 24 bits
  always_comb begin
    for (int k = 0; k < NOPS; k++) begin
      op_ext[k] = AW'($signed(tap_out[k]));                                // RULE25
    end
  end

  // Two signed 12x12 multipliers, registered; 24 bits hold any product
  always_ff @(posedge clk_i) begin
    prod_ab_r <= op_ext[0] * op_ext[1];                                    // RULE22
    prod_cd_r <= op_ext[2] * op_ext[3];                                    // RULE22
  end

  // Negation turns each product into a subtraction
  always_comb begin
    sum_nxt = '0;
    sum_nxt = ctl_p[3].neg_ab ? sum_nxt - prod_ab_r : sum_nxt + prod_ab_r; // RULE9 RULE10
    sum_nxt = ctl_p[3].neg_cd ? sum_nxt - prod_cd_r : sum_nxt + prod_cd_r; // RULE9 RULE10
  end

  always_ff @(posedge clk_i) begin
    sum_r <= sum_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chain alignment: three delays, or skipped for device-to-device chaining
  // Gating happens before the delays, so a gated word stays zero throughout
  always_ff @(posedge clk_i) begin
    chn_d_r[0] <= chain_r;                                                 // RULE12
    for (int i = 1; i < dmm_pkg::CHAIN_DLY; i++) begin
      chn_d_r[i] <= chn_d_r[i-1];
    end
  end

  // Bypass trades alignment for less latency through the chain
  assign chain_ext = ctl_p[4].bypass
                   ? AW'($signed(chain_r))                                 // RULE13 RULE25
                   : AW'($signed(chn_d_r[dmm_pkg::CHAIN_DLY-1]));          // RULE12 RULE25

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator; rounding only on a restart so errors never pile up
  // Wraps at 24 bits: long runs of large products overflow silently
  always_comb begin
    acc_nxt = sum_r + chain_ext;
    if (ctl_p[4].rnd && !ctl_p[4].cont) begin                              // RULE16
      acc_nxt = acc_nxt + $signed(dmm_pkg::RND_ONE);                       // RULE24
    end
    if (ctl_p[4].cont) begin
      acc_nxt = acc_nxt + acc_r;                                           // RULE15
    end                                                                    // RULE14
  end

  always_ff @(posedge clk_i) begin
    acc_r <= acc_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register: upper word each cycle, or alternating frozen words
  // Lower reads come from a frozen copy so both halves belong together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_out_o <= dmm_pkg::RES_RST;
      hold_r       <= '0;
      phase_r      <= 1'b1;
    end else if (ctl_p[5].upper) begin
      result_out_o <= acc_r[AW-1:dmm_pkg::UPPER_LSB];                      // RULE17 RULE19
      hold_r       <= acc_r;
      phase_r      <= 1'b1;
    end else begin
      // No new result is taken while the select stays low
      result_out_o <= phase_r ? hold_r[dmm_pkg::RES_W-1:0]                 // RULE18 RULE19
                              : hold_r[AW-1:dmm_pkg::UPPER_LSB];
      phase_r      <= !phase_r;
    end
  end

  // Drive enable bypasses every register so the pins release at once
  assign result_oe_o = !pin_drive_gate_n_i;                                // RULE20 RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cap_a;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |=> in_r[0] == $past(operand_a_i);
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("operand a not captured"); // RULE2

  property p_push_path;
    @(posedge clk_i) disable iff (!rstn_i)
      !stack_push_gate_n_i[1] |-> ##2 stk_r[1][0] == $past(operand_b_i, 2);
  endproperty
  a_push_path: assert property (p_push_path) else $error("push lost data"); // RULE3

  property p_push_shift;
    @(posedge clk_i) disable iff (!rstn_i)
      !gate_n_r[2] |=> stk_r[2][STK_DEPTH-1] == $past(stk_r[2][STK_DEPTH-2]);
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("stack not shifted"); // RULE5

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      gate_n_r[3] |=> stk_r[3][0] == $past(stk_r[3][0])
                   && stk_r[3][5] == $past(stk_r[3][5]);
  endproperty
  a_hold: assert property (p_hold) else $error("held stack changed"); // RULE6

  property p_tap_deep;
    @(posedge clk_i) disable iff (!rstn_i)
      tap_select_i[0] == 4'hF ##1 1'b1 |-> tap_out[0] == stk_r[0][STK_DEPTH-1];
  endproperty
  a_tap_deep: assert property (p_tap_deep) else $error("tap 15 wrong stage"); // RULE7

  property p_chain_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      chain_gate_n_i |=> chain_r == dmm_pkg::CHAIN_ZERO;
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("gated chain used"); // RULE11

  property p_chain_delay;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |-> ##3 chn_d_r[dmm_pkg::CHAIN_DLY-1] == $past(chain_r, 3);
  endproperty
  a_chain_delay: assert property (p_chain_delay) else $error("chain delay not 3"); // RULE12

  property p_restart;
    @(posedge clk_i) disable iff (!rstn_i)
      !ctl_p[4].cont && !ctl_p[4].rnd |=> acc_r == $past(sum_r) + $past(chain_ext);
  endproperty
  a_restart: assert property (p_restart) else $error("total not cleared"); // RULE14

  property p_round;
    @(posedge clk_i) disable iff (!rstn_i)
      ctl_p[4].rnd && !ctl_p[4].cont
        |=> acc_r == $past(sum_r) + $past(chain_ext) + $signed(dmm_pkg::RND_ONE);
  endproperty
  a_round: assert property (p_round) else $error("round not applied"); // RULE16

  property p_upper;
    @(posedge clk_i) disable iff (!rstn_i)
      upper_word_select_i |-> ##6 result_out_o == $past(acc_r[AW-1:8]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper word not shown"); // RULE17

  property p_lower_alt;
    @(posedge clk_i) disable iff (!rstn_i)
      ctl_p[5].upper ##1 !ctl_p[5].upper
        |=> result_out_o == $past(hold_r[dmm_pkg::RES_W-1:0]) && hold_r == $past(hold_r);
  endproperty
  a_lower_alt: assert property (p_lower_alt) else $error("lower word order wrong"); // RULE18

  property p_drive;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |-> result_oe_o == !pin_drive_gate_n_i;
  endproperty
  a_drive: assert property (p_drive) else $error("drive gate not obeyed"); // RULE20

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic and alignment checks
  property p_neg_ab;
    @(posedge clk_i) disable iff (!rstn_i)
      ctl_p[3].neg_ab && !ctl_p[3].neg_cd |=> sum_r == $past(prod_cd_r) - $past(prod_ab_r);
  endproperty
  a_neg_ab: assert property (p_neg_ab) else $error("product not negated"); // RULE9

  property p_accum;
    @(posedge clk_i) disable iff (!rstn_i)
      ctl_p[4].cont |=> acc_r == $past(acc_r) + $past(sum_r) + $past(chain_ext);
  endproperty
  a_accum: assert property (p_accum) else $error("sum not accumulated"); // RULE15

  property p_bypass;
    @(posedge clk_i) disable iff (!rstn_i)
      ctl_p[4].bypass |-> chain_ext[CW-1:0] == chain_r;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not taken"); // RULE13

  property p_chain_cap;
    @(posedge clk_i) disable iff (!rstn_i)
      !chain_gate_n_i |=> chain_r == $past(chain_in_port_i);
  endproperty
  a_chain_cap: assert property (p_chain_cap) else $error("chain not captured"); // RULE4

  property p_ctl_align;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |-> ##4 ctl_p[4] == $past(ctl_in, 4);
  endproperty
  a_ctl_align: assert property (p_ctl_align) else $error("control pipe misaligned"); // RULE23

  property p_tap_zero;
    @(posedge clk_i) disable iff (!rstn_i)
      tap_r[1] == 4'h0 |-> tap_out[1] == stk_r[1][0];
  endproperty
  a_tap_zero: assert property (p_tap_zero) else $error("tap 0 wrong stage"); // RULE7

  property p_phase;
    @(posedge clk_i) disable iff (!rstn_i)
      !ctl_p[5].upper |=> phase_r != $past(phase_r);
  endproperty
  a_phase: assert property (p_phase) else $error("word phase not toggled"); // RULE18

endmodule : dmm_mixer

//--- test/dmm_tb_pkg.sv
// Stimulus word that the upstream model hands to the mixer each clock
package dmm_tb_pkg;

  ////////////////////////////////////////////////////////////
  // One clock's worth of mixer inputs, index 0..3 = a..d
  typedef struct packed {
    logic [dmm_pkg::N_OPS-1:0][dmm_pkg::OP_W-1:0]  op;      // Operands
    logic [dmm_pkg::N_OPS-1:0]                     push_n;  // Stack push gates
    logic [dmm_pkg::N_OPS-1:0][dmm_pkg::TAP_W-1:0] tap;     // Tap selects
    logic [dmm_pkg::CHAIN_W-1:0]                   chain;   // Chain word
    logic                                          chain_n; // Chain gate
    logic                                          drv_n;   // Pin drive gate
    dmm_pkg::dmm_ctl_t                             ctl;     // Arithmetic controls
  } dmm_stim_t;

endpackage : dmm_tb_pkg

//--- test/dmm_upstream.sv
// Upstream logic model: presents one stimulus word to the mixer every clock
`timescale 1ns/100ps

module dmm_upstream #(
  parameter int FILL = 20                      // Zero-fill cycles after reset
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Word requested by the bench, word seen by the mixer
  input  wire dmm_tb_pkg::dmm_stim_t stim_i,
  output dmm_tb_pkg::dmm_stim_t      stim_o
);

  ////////////////////////////////////////////////////////////
  logic [7:0]            fill_r;               // Fill cycles still to go
  dmm_tb_pkg::dmm_stim_t word_r;               // Registered word

  // Stacks and taps come up unknown, so push zeros with taps 0 first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fill_r <= 8'(FILL);
      word_r <= '0;
    end else if (fill_r != 8'h00) begin
      fill_r <= fill_r - 8'h01;
      word_r <= '0;
    end else begin
      word_r <= stim_i;
    end
  end

  // Inputs are defined from time zero, even before the first edge
  assign stim_o = (rstn_i === 1'b1) ? word_r : '0;

endmodule : dmm_upstream

//--- test/test_dmm_mixer.sv
// Self-checking bench for the dual multiply-accumulate mixer
`timescale 1ns/100ps

module test_dmm_mixer;

  ////////////////////////////////////////////////////////////
  logic                  clk_i = 1'b0;         // Bench clock
  logic                  rstn_i = 1'b0;        // Reset, active low
  dmm_tb_pkg::dmm_stim_t s;                    // Word the bench asks for next
  dmm_tb_pkg::dmm_stim_t st;                   // Word the mixer sees
  logic [15:0]           res;                  // Result pins
  logic                  oe;                   // Pin drive enable
  logic [23:0]           p;                    // Accumulator copy
  int                    taps [3] = '{15, 7, 0}; // Tap codes, ending at 0
  int                    n_fail = 0;           // Mismatches
  int                    n_tests = 0;          // Comparisons

  always #(dmm_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  dmm_upstream u_up (.clk_i(clk_i), .rstn_i(rstn_i), .stim_i(s), .stim_o(st));

  dmm_mixer u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .operand_a_i(st.op[0]), .operand_b_i(st.op[1]),
    .operand_c_i(st.op[2]), .operand_d_i(st.op[3]),
    .stack_push_gate_n_i(st.push_n), .tap_select_i(st.tap),
    .chain_in_port_i(st.chain), .chain_gate_n_i(st.chain_n),
    .chain_align_bypass_i(st.ctl.bypass),
    .product_invert_ab_i(st.ctl.neg_ab), .product_invert_cd_i(st.ctl.neg_cd),
    .sum_continue_i(st.ctl.cont), .round_request_i(st.ctl.rnd),
    .upper_word_select_i(st.ctl.upper), .pin_drive_gate_n_i(st.drv_n),
    .result_out_o(res), .result_oe_o(oe)
  );

  ////////////////////////////////////////////////////////////
  // Signed sum of both products and the gated chain word, 24-bit wrap
  function automatic logic [23:0] sop(input dmm_tb_pkg::dmm_stim_t t);
    logic signed [23:0] ab;
    logic signed [23:0] cd;
    ab = $signed(t.op[0]) * $signed(t.op[1]);
    cd = $signed(t.op[2]) * $signed(t.op[3]);
    if (t.ctl.neg_ab) ab = -ab;
    if (t.ctl.neg_cd) cd = -cd;
    return ab + cd + (t.chain_n ? 24'h000000 : {{8{t.chain[15]}}, t.chain});
  endfunction : sop

  // Upper word of a fresh (non-accumulating) total, round included
  function automatic logic [15:0] exp_up(input dmm_tb_pkg::dmm_stim_t t);
    logic [23:0] v;
    v = sop(t) + ((t.ctl.rnd && !t.ctl.cont) ? 24'h000080 : 24'h000000);
    return v[23:8];
  endfunction : exp_up

  // Advance n clocks to a falling edge, where outputs have settled
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_i);
      @(negedge clk_i);
    end
  endtask : cyc

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Hold the word long enough to flush the pipe, then compare
  task automatic steady;
    cyc(10);
    check(res, exp_up(s));
  endtask : steady

  task automatic final_report;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    s = '0;
    s.ctl.upper = 1'b1;
    s.op = {12'h7FF, 12'h100, 12'h200, 12'hFFD};
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    check(res, dmm_pkg::RES_RST);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    cyc(30);
    for (int k = 0; k < 4; k++) begin
      {s.ctl.neg_cd, s.ctl.neg_ab} = 2'(k);
      steady();
    end
    s.chain = 16'h8000;
    for (int k = 0; k < 2; k++) begin
      s.chain_n = k[0];
      steady();
    end
    $display("negate and chain gate test done");
    s.ctl = '0;
    s.ctl.upper = 1'b1;
    s.op = {12'h000, 12'h000, 12'h080, 12'h201};
    for (int k = 0; k < 2; k++) begin
      s.ctl.rnd = k[0];
      steady();
    end
    s.ctl.cont = 1'b1;
    cyc(6);
    for (int j = 0; j < 4; j++) begin
      cyc(1);
      check(res, 16'(24'(sop(s) * 24'(j + 2) + 24'h000080) >> 8));
    end
    s.ctl.cont = 1'b0;
    steady();
    $display("round and accumulate test done");
    s.ctl.rnd = 1'b0;
    s.op = {12'h000, 12'h000, 12'h0F1, 12'h123};
    p = sop(s);
    steady();
    s.ctl.upper = 1'b0;
    cyc(1);
    s.op = '0;
    cyc(6);
    for (int j = 0; j < 4; j++) begin
      check(res, j[0] ? p[23:8] : p[15:0]);
      cyc(1);
    end
    s.ctl.upper = 1'b1;
    $display("word select test done");
    s.op = {12'h000, 12'h000, 12'h100, 12'h000};
    for (int k = 0; k < 3; k++) begin
      s.tap[0] = 4'(taps[k]);
      for (int i = 0; i < 40; i++) begin
        s.op[0] = 12'(i);
        cyc(1);
        if (i > 23) check(res, 16'(i - 6 - taps[k]));
      end
    end
    s.push_n[0] = 1'b1;
    s.op[0] = 12'h7FF;
    cyc(10);
    check(res, 16'h0027);
    s.push_n[0] = 1'b0;
    steady();
    $display("delay stack test done");
    s.op = '0;
    s.chain_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      s.ctl.bypass = k[0];
      s.chain = '0;
      steady();
      s.chain = 16'h8000;
      for (int m = 1; m < 9; m++) begin
        cyc(1);
        s.chain = '0;
        check(res, (m == (k[0] ? 4 : 7)) ? 16'hFF80 : 16'h0000);
      end
    end
    $display("chain alignment test done");
    for (int k = 0; k < 2; k++) begin
      s.drv_n = ~k[0];
      cyc(1);
      check(16'(oe), 16'(k[0]));
    end
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    check(res, dmm_pkg::RES_RST);
    $display("pin drive and reset test done");
    final_report();
  end

  // Cut a hung run short
  initial begin
    #400000;
    n_fail++;
    $display("wrong value at %0t: got %h exp %h", $time, 1'b0, 1'b1);
    final_report();
  end

endmodule : test_dmm_mixer
